// ===== inc/ifb_pkg.sv
// Package: register map, field layouts and bus types of the flag bank
package ifb_pkg;

    localparam logic [11:0] OFF_FLAG2 = 12'h000;
    localparam logic [11:0] OFF_FLAG3 = 12'h004;
    localparam logic [11:0] OFF_ENABLE2 = 12'h008;
    localparam logic [11:0] OFF_ENABLE3 = 12'h00c;
    localparam logic [11:0] OFF_SUMMARY = 12'h010;
    localparam logic [11:0] OFF_MASK = 12'h014;

    // Implemented bit masks; other positions read as zero
    localparam logic [15:0] FLAG2_IMPL = 16'hdfff;
    localparam logic [15:0] FLAG3_IMPL = 16'ha7ff;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Third register bit positions
    localparam int B3_PWM_FAULT_A = 15;
    localparam int B3_DMA_CH5 = 13;
    localparam int B3_ENCODER = 10;
    localparam int B3_PWM_ERROR = 9;
    localparam int B3_CAN2_EVENT = 8;
    localparam int B3_CAN2_RX = 7;
    localparam int B3_EXT_PIN4 = 6;
    localparam int B3_EXT_PIN3 = 5;
    localparam int B3_TIMER9 = 4;
    localparam int B3_TIMER8 = 3;
    localparam int B3_I2C2_MASTER = 2;
    localparam int B3_I2C2_SLAVE = 1;
    localparam int B3_TIMER7 = 0;

    // Second register bit positions
    localparam int B2_TIMER6 = 15;
    localparam int B2_DMA_CH4 = 14;
    localparam int B2_OC8 = 12;
    localparam int B2_IC6 = 8;
    localparam int B2_DMA_CH3 = 4;
    localparam int B2_CAN1_EVENT = 3;
    localparam int B2_CAN1_RX = 2;
    localparam int B2_SPI2_EVENT = 1;
    localparam int B2_SPI2_ERROR = 0;

    // Summary status bits
    localparam int SUM_BANK2 = 0;
    localparam int SUM_BANK3 = 1;
    localparam logic [1:0] SUM_IMPL = 2'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic [15:0] bank2;
        logic [15:0] bank3;
    } ifb_events_s;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } ifb_ahb_req_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DATA = 2'b10
    } ifb_state_e;

endpackage

// ===== hdl/ifb_bank.sv
// Interrupt flag and enable bank behind an AHB-Lite slave port
import ifb_pkg::*;

// Function
// - A flag reads one once its source raised a request, else zero.
// - An enable of one passes its source's request to irq_pending; zero blocks it there, but the summary bit still sets.
// - Unimplemented flag and enable positions always read as zero.
// - All implemented flag and enable bits are read/write, zero at reset.
// - Third enable upper byte: fault A 15, DMA5 13, encoder 10, PWM 9, CAN2 8.
// - Third enable lower byte: CAN2 rx, pins 4/3, timers 9/8, I2C2, timer7.
// - Third flag register shares the third enable layout; CAN2 rx at 7.
// - External pin 3 flag at bit 5, pin 4 flag at bit 6.
module ifb_bank (
    input wire logic hclk,
    input wire logic hresetn,
    input wire ifb_pkg::ifb_ahb_req_s ahb_req,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ifb_pkg::ifb_events_s events,
    output ifb_pkg::ifb_events_s irq_pending,
    output logic irq
);
    import ifb_pkg::*;

    // Implemented positions, assembled from the named source positions;
    // a position moved in the package moves the bit here as well
    localparam logic [15:0] MAP2 =
        (16'h0001 << B2_TIMER6) |
        (16'h0001 << B2_DMA_CH4) |
        (16'h0001 << B2_OC8) |
        (16'h0001 << (B2_OC8 - 1)) |
        (16'h0001 << (B2_OC8 - 2)) |
        (16'h0001 << (B2_OC8 - 3)) |
        (16'h0001 << B2_IC6) |
        (16'h0001 << (B2_IC6 - 1)) |
        (16'h0001 << (B2_IC6 - 2)) |
        (16'h0001 << (B2_IC6 - 3)) |
        (16'h0001 << B2_DMA_CH3) |
        (16'h0001 << B2_CAN1_EVENT) |
        (16'h0001 << B2_CAN1_RX) |
        (16'h0001 << B2_SPI2_EVENT) |
        (16'h0001 << B2_SPI2_ERROR);

    // Third bank: flags and enables share this one layout
    localparam logic [15:0] MAP3 =
        (16'h0001 << B3_PWM_FAULT_A) |
        (16'h0001 << B3_DMA_CH5) |
        (16'h0001 << B3_ENCODER) |
        (16'h0001 << B3_PWM_ERROR) |
        (16'h0001 << B3_CAN2_EVENT) |
        (16'h0001 << B3_CAN2_RX) |
        (16'h0001 << B3_EXT_PIN4) |
        (16'h0001 << B3_EXT_PIN3) |
        (16'h0001 << B3_TIMER9) |
        (16'h0001 << B3_TIMER8) |
        (16'h0001 << B3_I2C2_MASTER) |
        (16'h0001 << B3_I2C2_SLAVE) |
        (16'h0001 << B3_TIMER7);

    logic [15:0] flag2;
    logic [15:0] flag3;
    logic [15:0] enable2;
    logic [15:0] enable3;
    logic [1:0] summary;
    logic [1:0] mask;
    logic [15:0] next_flag2;
    logic [15:0] next_flag3;
    logic [15:0] next_enable2;
    logic [15:0] next_enable3;
    logic [1:0] next_summary;
    logic [1:0] next_mask;
    ifb_events_s next_pending;
    logic next_irq;

    ifb_state_e state;
    ifb_state_e next_state;
    logic [11:0] addr;
    logic [11:0] next_addr;
    logic wr;
    logic next_wr;
    logic [31:0] next_hrdata;

    logic take;
    logic wr_flag2;
    logic wr_flag3;
    logic wr_en2;
    logic wr_en3;
    logic wr_sum;
    logic wr_mask;
    logic [15:0] wd;
    logic [1:0] sum_event;
    wire logic [15:0] set2;
    wire logic [15:0] set3;

    // Per-bit source qualification: an event reaches only an implemented
    // bit, so unused positions can never be set from outside
    for (genvar b = 0; b < 16; b++) begin : g_src
        assign set2[b] = events.bank2[b] & MAP2[b];
        assign set3[b] = events.bank3[b] & MAP3[b];
    end

    // Bus front end: one address phase, zero-wait data phase
    always_comb begin
        take = ahb_req.hsel && ahb_req.hready &&
            ahb_req.htrans == HTRANS_NONSEQ;
        next_state = state;
        next_addr = addr;
        next_wr = wr;
        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (!take) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
        if (take) begin
            next_addr = ahb_req.haddr[11:0];
            next_wr = ahb_req.hwrite;
        end else if (state == ST_DATA) begin
            next_wr = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            addr <= 12'h000;
            wr <= 1'b0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            wr <= next_wr;
        end
    end

    // Write strobes in the data phase
    always_comb begin
        wd = hwdata[15:0];
        wr_flag2 = state == ST_DATA && wr && addr == OFF_FLAG2;
        wr_flag3 = state == ST_DATA && wr && addr == OFF_FLAG3;
        wr_en2 = state == ST_DATA && wr && addr == OFF_ENABLE2;
        wr_en3 = state == ST_DATA && wr && addr == OFF_ENABLE3;
        wr_sum = state == ST_DATA && wr && addr == OFF_SUMMARY;
        wr_mask = state == ST_DATA && wr && addr == OFF_MASK;
    end

    // Second flag bank: a write stores the value, a source event sets
    always_comb begin
        next_flag2 = flag2;
        if (wr_flag2) begin
            next_flag2 = wd & MAP2;
        end
        // Source events win over a same-cycle software clear
        next_flag2 = next_flag2 | set2;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag2 <= REG_RESET;
        end else begin
            flag2 <= next_flag2;
        end
    end

    // Third flag bank: same behaviour, third layout
    always_comb begin
        next_flag3 = flag3;
        if (wr_flag3) begin
            next_flag3 = wd & MAP3;
        end
        // Source events win over a same-cycle software clear
        next_flag3 = next_flag3 | set3;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag3 <= REG_RESET;
        end else begin
            flag3 <= next_flag3;
        end
    end

    // Second enable bank, laid out like the second flags
    always_comb begin
        next_enable2 = enable2;
        if (wr_en2) begin
            next_enable2 = wd & MAP2;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable2 <= REG_RESET;
        end else begin
            enable2 <= next_enable2;
        end
    end

    // Third enable bank
    always_comb begin
        next_enable3 = enable3;
        if (wr_en3) begin
            next_enable3 = wd & MAP3;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable3 <= REG_RESET;
        end else begin
            enable3 <= next_enable3;
        end
    end

    // Summary status: sticky per bank, write one to clear, set wins
    always_comb begin
        sum_event[SUM_BANK2] = |set2;
        sum_event[SUM_BANK3] = |set3;
        next_summary = summary;
        if (wr_sum) begin
            next_summary = summary & ~wd[1:0];
        end
        next_summary = (next_summary | sum_event) & SUM_IMPL;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            summary <= 2'h0;
        end else begin
            summary <= next_summary;
        end
    end

    // Summary mask
    always_comb begin
        next_mask = mask;
        if (wr_mask) begin
            next_mask = wd[1:0] & SUM_IMPL;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= 2'h0;
        end else begin
            mask <= next_mask;
        end
    end

    // Pending view and interrupt line follow the next values, so they
    // change on the same edge as the flags they come from
    always_comb begin
        next_pending.bank2 = next_flag2 & next_enable2;
        next_pending.bank3 = next_flag3 & next_enable3;
        next_irq = |(next_summary & next_mask) ||
            (|next_pending.bank2) || (|next_pending.bank3);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_pending <= '0;
            irq <= 1'b0;
        end else begin
            irq_pending <= next_pending;
            irq <= next_irq;
        end
    end

    // Read data registered at address phase for the data phase
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (take && !ahb_req.hwrite) begin
            unique case (ahb_req.haddr[11:0])
                OFF_FLAG2: next_hrdata = {16'h0000, flag2};
                OFF_FLAG3: next_hrdata = {16'h0000, flag3};
                OFF_ENABLE2: next_hrdata = {16'h0000, enable2};
                OFF_ENABLE3: next_hrdata = {16'h0000, enable3};
                OFF_SUMMARY: next_hrdata = {30'h0, summary};
                OFF_MASK: next_hrdata = {30'h0, mask};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule // ifb_bank

// ===== tb/ifb_bank_chk.sv
// Checker: bus response and pending output relations of the flag bank
module ifb_bank_chk
import ifb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire ifb_pkg::ifb_ahb_req_s ahb_req,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire ifb_pkg::ifb_events_s events,
    input wire ifb_pkg::ifb_events_s irq_pending,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wr_d;
    logic rd_d;
    logic tk;
    assign tk = ahb_req.hsel & ahb_req.hready &
        (ahb_req.htrans == HTRANS_NONSEQ);
    // Marks the data phase of a taken write or read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_d <= 1'b0;
            rd_d <= 1'b0;
        end else begin
            wr_d <= tk & ahb_req.hwrite;
            rd_d <= tk & ~ahb_req.hwrite;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    a_upper_zero: assert property (rd_d |-> hrdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_idle_zero: assert property (!rd_d |-> hrdata == 32'h0)
        else $error("read data outside a read");
    a_pend_impl: assert property ((irq_pending & ~{FLAG2_IMPL, FLAG3_IMPL})
        == 32'h0) else $error("pending on unused bit");
    a_pend_sticky: assert property (|($past(irq_pending) & ~irq_pending)
        |-> $past(wr_d)) else $error("pending fell without write");
    a_pend_cause: assert property (|(irq_pending & ~$past(irq_pending)
        & ~$past(events)) |-> $past(wr_d)) else $error("pending rose alone");
    a_irq_level: assert property (|irq_pending |-> irq)
        else $error("irq low while pending");
endmodule // ifb_bank_chk
bind ifb_bank ifb_bank_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .ahb_req(ahb_req), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .events(events), .irq_pending(irq_pending), .irq(irq));

// ===== tb/ifb_periph.sv
// Peripheral model: raises event strobes when the bench commands
module ifb_periph
import ifb_pkg::*;
(
    input wire logic hclk,
    input wire logic go,
    input wire logic [31:0] pattern,
    output ifb_pkg::ifb_events_s events
);
    timeunit 1ns;
    timeprecision 100ps;
    initial events = '0;
    // One-cycle strobe per command; lines sit low otherwise
    always @(posedge hclk) begin
        events <= go ? pattern : 32'h0;
    end
endmodule // ifb_periph

// ===== tb/ifb_bank_test.sv
// Testbench: register, event and interrupt checks against a bench model
module ifb_bank_test;
import ifb_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, pattern = 32'h0;
    logic [31:0] rnd = 32'h1f;
    logic [1:0] htrans = 2'h0, sm = 2'h0, mk = 2'h0;
    logic hwrite = 1'b0, hsel = 1'b0, hreadyout, hresp, irq, go = 1'b0;
    logic [15:0] f2 = 16'h0, f3 = 16'h0, e2 = 16'h0, e3 = 16'h0;
    ifb_events_s events, irq_pending;
    int error_cnt = 0;
    int checks = 0;
    always #2 hclk = ~hclk;
    ifb_bank dut (.hclk(hclk), .hresetn(hresetn),
        .ahb_req({haddr, htrans, hwrite, HSIZE_WORD, hsel, hreadyout}),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .events(events), .irq_pending(irq_pending), .irq(irq));
    ifb_periph u_periph (.hclk(hclk), .go(go), .pattern(pattern),
        .events(events));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w,
        input logic [31:0] d);
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic zero_chk;
        for (int a = 0; a <= 'h18; a += 4) begin
            bus(a[11:0], 1'b0, 32'h0);
            chk("reset value", 32'h0, q);
        end
    endtask
    task automatic model_chk;
        #1;
        chk("irq_pending", {f2 & e2, f3 & e3}, irq_pending);
        chk("irq", {31'h0, |{f2 & e2, f3 & e3, sm & mk}}, {31'h0, irq});
        @(posedge hclk);
        bus(OFF_FLAG2, 1'b0, 32'h0);
        chk("flag2", {16'h0, f2}, q);
        bus(OFF_FLAG3, 1'b0, 32'h0);
        chk("flag3", {16'h0, f3}, q);
        bus(OFF_SUMMARY, 1'b0, 32'h0);
        chk("summary", {30'h0, sm}, q);
    endtask
    task automatic results;
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #40000;
        error_cnt++;
        results();
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        zero_chk();
        for (int i = 0; i < 4; i++) begin
            bus(12'(i * 4), 1'b1, 32'hffffffff);
            bus(12'(i * 4), 1'b0, 32'h0);
            chk("ones", {16'h0, i[0] ? FLAG3_IMPL : FLAG2_IMPL}, q);
            bus(12'(i * 4), 1'b1, 32'h0);
            bus(12'(i * 4), 1'b0, 32'h0);
            chk("zeros", 32'h0, q);
        end
        bus(12'h018, 1'b1, 32'hffffffff);
        bus(12'h018, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
        repeat (12) begin
            rnd = lfsr(rnd);
            e2 = rnd[31:16] & FLAG2_IMPL;
            e3 = rnd[15:0] & FLAG3_IMPL;
            mk = rnd[17:16];
            bus(OFF_ENABLE2, 1'b1, {16'hffff, rnd[31:16]});
            bus(OFF_ENABLE3, 1'b1, {16'h0, rnd[15:0]});
            bus(OFF_MASK, 1'b1, {30'h0, mk});
            rnd = lfsr(lfsr(rnd));
            pattern <= rnd & {FLAG2_IMPL, FLAG3_IMPL};
            go <= 1'b1;
            @(posedge hclk);
            go <= 1'b0;
            f2 |= rnd[31:16] & FLAG2_IMPL;
            f3 |= rnd[15:0] & FLAG3_IMPL;
            sm |= {|(rnd[15:0] & FLAG3_IMPL), |(rnd[31:16] & FLAG2_IMPL)};
            repeat (3) @(posedge hclk);
            model_chk();
            rnd = lfsr(rnd);
            pattern <= {16'h0, rnd[15:0]} & {FLAG2_IMPL, FLAG3_IMPL};
            go <= 1'b1;
            fork
                bus(OFF_FLAG3, 1'b1, 32'h0);
                begin
                    @(posedge hclk);
                    go <= 1'b0;
                end
            join
            f3 = rnd[15:0] & FLAG3_IMPL;
            sm |= {|(rnd[15:0] & FLAG3_IMPL), 1'b0};
            bus(OFF_SUMMARY, 1'b1, {30'h0, rnd[5:4]});
            sm &= ~rnd[5:4];
            model_chk();
        end
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("irq after reset", 32'h0, {31'h0, irq});
        chk("pending after reset", 32'h0, irq_pending);
        zero_chk();
        results();
    end
endmodule // ifb_bank_test
